//--- rtl/sar_frame_regs.vh
// Purpose: constants for the serial conversion-frame logic
// Assumes: 8-bit result, two leading zeros, counts in falling SCLK edges
// Notes: definitions only
`ifndef SAR_FRAME_REGS_VH
`define SAR_FRAME_REGS_VH
`define RES_BITS 8
`define CNT_W 6
`define LEAD_EDGES 6'h01
`define DATA_LAST_EDGE 6'h08
`define PWRUP_CAL_EDGES 6'h10
`define RECAL_START_EDGE 6'h11
`define RECAL_EDGES 6'h20
`define CODE_ZERO 8'h00
`define CODE_FULL 8'hFF
`define OFFSET_RESET 9'h000
`endif

//--- rtl/sar_step.v
// Purpose: one successive-approximation step per SCLK falling edge
// Assumes: comparator decision arrives from the analog stage per trial
// Notes: trial bit walks from MSB to LSB
`timescale 1ns/1ps
`include "sar_frame_regs.vh"
module sar_step (
   input wire clk_sys, // System clock
   input wire reset_n, // Async reset, active low
   input wire start, // Pulse: new sample taken
   input wire step, // Pulse: SCLK falling edge during conversion
   input wire cmp_high, // Comparator: input above trial level
   output reg [7:0] trial_q, // Trial code to the DAC
   output reg [7:0] result_q, // Final code
   output reg done_q // Level: conversion complete
);
   reg [7:0] bit_q;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         trial_q <= 8'h80;
         bit_q <= 8'h80;
         result_q <= 8'h00;
         done_q <= 1'b0;
      end else if (start) begin
         trial_q <= 8'h80;
         bit_q <= 8'h80;
         done_q <= 1'b0;
      end else if (step && !done_q) begin
         if (bit_q == 8'h01) begin
            done_q <= 1'b1;
            result_q <= cmp_high ? trial_q : (trial_q & ~bit_q);
         end else begin
            trial_q <= (cmp_high ? trial_q : (trial_q & ~bit_q)) | (bit_q >> 1);
            bit_q <= bit_q >> 1;
         end
      end
   end
endmodule

//--- rtl/sar_adc_serial_frame.v
// Purpose: serial frame, conversion sequencing and offset calibration
// Assumes: SCLK and chip select are async pins, sampled on clk_sys
// Notes: reset_n stands for the analog-supply power cycle
// Operation
// R1 - Chip-select fall samples the differential input and starts converting
// R2 - SCLK alone steps conversion and shifts result bits
// R3 - Frame runs from chip-select fall to rise, one conversion each
// R4 - Host waits setup time before first SCLK falling edge
// R5 - Setup at least 15 ns, SCLK at most 12 MHz; code needs setup and each SCLK phase to exceed one clk_sys period
// R6 - Zero at chip-select fall, another zero, then result bits
// R7 - Result leaves most significant bit first, ten bit periods; code sends eight result bits, ten periods counting the two zeros
// R8 - After tenth SCLK, SDO stays low until chip select rises
// R9 - Chip-select rise ends frame, SDO released
// R10 - Host allows acquisition interval before next frame
// R11 - Inputs disconnected while converting, reconnected for acquisition
// R12 - Result is 8-bit unsigned straight binary
// R13 - Codes 00 at bottom, 80 mid-scale, FF top
// R14 - First frame after power-up calibrates, SDO held low
// R15 - Power-up calibration needs 16 SCLK falls, else store unchanged
// R16 - Inputs disconnected while calibration runs
// R17 - Correction store not reachable through serial transfer
// R18 - Correction store cleared at power-up
// R19 - Recalibration allowed during normal operation
// R20 - Recalibration needs 32 SCLK falls in one frame
// R21 - Later results corrected by stored offset
// R22 - Only power cycle discards calibration and restores first-frame mode
`timescale 1ns/1ps
`include "sar_frame_regs.vh"
module sar_adc_serial_frame (
   input wire clk_sys, // System clock, 20 MHz
   input wire reset_n, // Power-up reset, active low
   input wire cs_n, // Chip select pin, active low
   input wire sclk, // Serial clock pin
   input wire cmp_high, // Comparator decision from analog stage
   input wire signed [8:0] offset_meas, // Offset measured by analog stage
   output reg sdo_o, // Serial data out
   output reg sdo_oe, // Serial data drive enable
   output reg sample_hold_q, // Sampling switch open (inputs held)
   output wire inputs_connected, // Analog inputs tied to sampler
   output wire [7:0] dac_code, // Trial code to capacitor DAC
   output reg cal_active_q // Calibration in progress
);
   reg [2:0] cs_sync_q;
   reg [2:0] sclk_sync_q;
   wire cs_fall = cs_sync_q[2] & ~cs_sync_q[1];
   wire cs_rise = ~cs_sync_q[2] & cs_sync_q[1];
   wire in_frame = ~cs_sync_q[1];
   wire sclk_fall = in_frame & sclk_sync_q[2] & ~sclk_sync_q[1];

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cs_sync_q <= 3'b111;
         sclk_sync_q <= 3'b000;
      end else begin
         cs_sync_q <= {cs_sync_q[1:0], cs_n};
         sclk_sync_q <= {sclk_sync_q[1:0], sclk};
      end
   end

   localparam ST_IDLE = 3'b001;
   localparam ST_CONV = 3'b010;
   localparam ST_CAL = 3'b100;

   reg [2:0] state_q;
   reg [`CNT_W-1:0] edge_q;
   reg first_frame_q;
   reg signed [8:0] offset_correction_store_q;
   reg dec_q;
   reg [7:0] dac_q;
   reg dac_over_q;
   reg dac_under_q;
   wire [7:0] trial_code;
   wire conv_done;
   wire cmp_eff;
   wire step = sclk_fall & (state_q == ST_CONV);

   // R21 - offset shifts DAC
   // Comparing against trial plus offset gives the corrected code bit by bit,
   // so each decided bit can leave on the next fall with no added latency
   wire signed [9:0] offset_ext = {offset_correction_store_q[8], offset_correction_store_q};
   wire signed [9:0] dac_sum = $signed({2'b00, trial_code}) + offset_ext;
   wire dac_over = ~dac_sum[9] & dac_sum[8];
   wire dac_under = dac_sum[9];

   // R13 - clamp at code ends
   // Level above FF can never pass, level below 00 always passes
   assign cmp_eff = dac_over_q ? 1'b0 : (dac_under_q ? 1'b1 : cmp_high);

   // R1 R2 R12 - SCLK-stepped SAR
   sar_step u_step (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .start(cs_fall),
      .step(step),
      .cmp_high(cmp_eff),
      .trial_q(trial_code),
      .result_q(),
      .done_q(conv_done)
   );

   // Registered so the DAC level is settled for a whole SCLK phase
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dac_q <= 8'h80;
         dac_over_q <= 1'b0;
         dac_under_q <= 1'b0;
      end else begin
         dac_over_q <= dac_over;
         dac_under_q <= dac_under;
         if (dac_over)
            dac_q <= `CODE_FULL;
         else if (dac_under)
            dac_q <= `CODE_ZERO;
         else
            dac_q <= dac_sum[7:0];
      end
   end

   assign dac_code = dac_q;

   // R7 - decision kept for next fall
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         dec_q <= 1'b0;
      else if (cs_fall)
         dec_q <= 1'b0;
      else if (step && !conv_done)
         dec_q <= cmp_eff;
   end

   // R11 R16 - switch control
   assign inputs_connected = ~sample_hold_q & ~cal_active_q;

   // R3 - one frame per select
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         edge_q <= 6'h00;
         // R22 - first-frame mode from reset only
         first_frame_q <= 1'b1;
      end else if (cs_rise) begin
         state_q <= ST_IDLE;
         first_frame_q <= 1'b0;
      end else if (cs_fall) begin
         edge_q <= 6'h00;
         // R14 - first frame calibrates
         state_q <= first_frame_q ? ST_CAL : ST_CONV;
      end else begin
         case (state_q)
            ST_IDLE: begin
               state_q <= ST_IDLE;
            end
            ST_CONV, ST_CAL: begin
               // Saturates so a long frame cannot wrap below the thresholds
               if (sclk_fall && edge_q != 6'h3F)
                  edge_q <= edge_q + 6'h01;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // R17 - written only from analog stage
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         // R18 - cleared at power-up
         offset_correction_store_q <= `OFFSET_RESET;
      end else if (cs_rise) begin
         // R15 - power-up cal needs 16 falls
         if (first_frame_q && edge_q >= `PWRUP_CAL_EDGES)
            offset_correction_store_q <= offset_meas;
         // R19 R20 - recal needs 32 falls
         else if (!first_frame_q && edge_q >= `RECAL_EDGES)
            offset_correction_store_q <= offset_meas;
      end
   end

   // R1 R11 R16 - sampling switch, cal flag
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sample_hold_q <= 1'b0;
         cal_active_q <= 1'b0;
      end else if (cs_rise) begin
         sample_hold_q <= 1'b0;
         cal_active_q <= 1'b0;
      end else if (cs_fall) begin
         sample_hold_q <= 1'b1;
         cal_active_q <= first_frame_q;
      end else begin
         // Reconnect for acquisition once the last trial is decided
         if (state_q == ST_CONV && conv_done)
            sample_hold_q <= 1'b0;
         // Recal window opens at fall 17 and runs to frame end
         if (step && edge_q == `RECAL_START_EDGE - 6'h01)
            cal_active_q <= 1'b1;
         else if (state_q == ST_CONV && sclk_fall && edge_q == `RECAL_START_EDGE - 6'h01)
            cal_active_q <= 1'b1;
      end
   end

   // R6 R9 - SDO driver
   // Limitation: a fall seen in the same cycle as select is lost
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sdo_o <= 1'b0;
         sdo_oe <= 1'b0;
      end else if (cs_rise) begin
         // R9 - release at frame end
         sdo_oe <= 1'b0;
         sdo_o <= 1'b0;
      end else if (cs_fall) begin
         // R6 - first zero at once
         sdo_oe <= 1'b1;
         sdo_o <= 1'b0;
      end else if (state_q == ST_CONV && sclk_fall) begin
         // R6 R7 - second zero, then MSB first
         if (edge_q < `LEAD_EDGES) begin
            sdo_o <= 1'b0;
         end else if (edge_q <= `DATA_LAST_EDGE) begin
            sdo_o <= dec_q;
         end else begin
            // R8 - low after tenth
            sdo_o <= 1'b0;
         end
      end else if (state_q != ST_CONV) begin
         // R14 - calibration frame stays low
         sdo_o <= 1'b0;
      end
   end
endmodule

//--- bench/sar_frame_sva.sv
// Purpose: port checks; Assumes: SCLK 400 ns; Notes: pin sync plus output register costs about 3 clk
`timescale 1ns/1ps
module sar_frame_sva (input wire clk_sys, input wire reset_n, input wire cs_n,
   input wire sclk, input wire cmp_high, input wire signed [8:0] offset_meas,
   input wire sdo_o, input wire sdo_oe, input wire sample_hold_q,
   input wire inputs_connected, input wire [7:0] dac_code, input wire cal_active_q);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   logic [5:0] falls;
   logic sclk_d;
   // Pin-level count of SCLK falls in the current frame
   always @(posedge clk_sys) begin
      sclk_d <= sclk;
      if (cs_n)
         falls <= 6'h00;
      else if (sclk_d && !sclk && falls != 6'h3F)
         falls <= falls + 6'h01;
   end
   property p_release; $rose(cs_n) |-> ##[1:6] !sdo_oe; endproperty
   a_release: assert property (p_release) else $error("SDO not released");
   property p_lead; $fell(cs_n) |-> ##[1:6] (sdo_oe && !sdo_o); endproperty
   a_lead: assert property (p_lead) else $error("no leading zero");
   property p_frame; sdo_oe && !cs_n |=> sdo_oe; endproperty
   a_frame: assert property (p_frame) else $error("SDO dropped in frame");
   property p_conn; (!cs_n && !cal_active_q && falls >= 6'h09) |-> inputs_connected; endproperty
   a_conn: assert property (p_conn) else $error("inputs not reconnected");
   property p_hold; (!cs_n && falls >= 6'h01 && falls <= 6'h07) |-> !inputs_connected; endproperty
   a_hold: assert property (p_hold) else $error("inputs open in conversion");
   property p_take; $fell(cs_n) |-> ##[1:6] !inputs_connected; endproperty
   a_take: assert property (p_take) else $error("no sample taken");
   property p_steady; (sclk && !cs_n) [*4] |=> $stable(sdo_o); endproperty
   a_steady: assert property (p_steady) else $error("SDO moved off SCLK");
   property p_cal_low; cal_active_q |-> !sdo_o; endproperty
   a_cal_low: assert property (p_cal_low) else $error("SDO high in calibration");
   property p_cal_end; cs_n [*6] |-> !cal_active_q; endproperty
   a_cal_end: assert property (p_cal_end) else $error("calibration outlived frame");
   c_cal: cover property ($fell(cal_active_q));
   c_conv: cover property ($rose(sample_hold_q));
   c_end: cover property ($fell(sdo_oe));
endmodule
bind sar_adc_serial_frame sar_frame_sva u_sva (.clk_sys, .reset_n, .cs_n, .sclk,
   .cmp_high, .offset_meas, .sdo_o, .sdo_oe, .sample_hold_q, .inputs_connected,
   .dac_code, .cal_active_q);

//--- bench/host_model.sv
// Purpose: host side of frame; Assumes: 400 ns SCLK; Notes: SCLK idles low
`timescale 1ns/1ps
module host_model (output logic cs_n, output logic sclk, input wire sdo_o,
   input wire sdo_oe);
   logic [39:0] got;
   // No pull on SDO: a released line reads inverted
   wire sdo_line = sdo_oe ? sdo_o : ~sdo_o;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      got = 40'h0;
   end
   task automatic frame(input int n);
      #13;
      cs_n = 1'b0;
      #400;
      for (int i = 0; i < n; i++) begin
         sclk = 1'b1;
         #200;
         got = {got[38:0], sdo_line};
         sclk = 1'b0;
         #200;
      end
      #200;
      got = {got[38:0], sdo_line};
      cs_n = 1'b1;
      #1000;
   endtask
endmodule

//--- bench/sar_adc_serial_frame_bench.sv
// Purpose: frame bench; Assumes: ideal comparator; Notes: host samples late in each bit
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
   $display("[FAIL] %0t sdo mismatch", $time); end end
module sar_adc_serial_frame_bench;
   logic clk_sys, reset_n;
   logic [7:0] vin;
   logic signed [8:0] offset_meas;
   wire cs_n, sclk, sdo_o, sdo_oe, sample_hold_q, inputs_connected, cal_active_q;
   wire [7:0] dac_code;
   wire cmp_high = (vin >= dac_code);
   int checks = 0, num_errors = 0;
   sar_adc_serial_frame DUT (.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n),
      .sclk(sclk), .cmp_high(cmp_high), .offset_meas(offset_meas), .sdo_o(sdo_o),
      .sdo_oe(sdo_oe), .sample_hold_q(sample_hold_q), .inputs_connected(inputs_connected),
      .dac_code(dac_code), .cal_active_q(cal_active_q));
   host_model HOST (.cs_n(cs_n), .sclk(sclk), .sdo_o(sdo_o), .sdo_oe(sdo_oe));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic conv(input logic [7:0] v, input int n, input logic [7:0] code);
      @(negedge clk_sys) vin = v;
      HOST.frame(n);
      `CHK(HOST.got[n -: 10], {2'b00, code}) // lead zeros then msb first
      `CHK(HOST.got & ~({40{1'b1}} << (n - 9)), 40'h0) // low after bit ten
   endtask
   task automatic cal(input int n, input logic signed [8:0] off);
      @(negedge clk_sys) offset_meas = off;
      HOST.frame(n);
      `CHK(HOST.got & ~({40{1'b1}} << (n + 1)), 40'h0) // all low
   endtask
   task automatic first_short;
      cal(8, 9'sh005);
      conv(8'h80, 11, 8'h80); // store still zero
      conv(8'h00, 10, 8'h00);
      conv(8'hFF, 12, 8'hFF);
   endtask
   task automatic recal;
      @(negedge clk_sys) offset_meas = 9'sh003;
      conv(8'h80, 32, 8'h80);
      conv(8'h80, 10, 8'h7D);
      conv(8'h00, 10, 8'h00); // clamp
   endtask
   task automatic short_recal;
      @(negedge clk_sys) offset_meas = 9'sh009;
      conv(8'h40, 31, 8'h3D);
      conv(8'h80, 10, 8'h7D); // store kept
   endtask
   task automatic repower;
      @(negedge clk_sys) reset_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      reset_n = 1'b1;
      cal(16, -9'sh002);
      conv(8'h80, 10, 8'h82);
      conv(8'hFF, 10, 8'hFF); // clamp
   endtask
   task automatic wrap_up;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      reset_n = 1'b0;
      vin = 8'h00;
      offset_meas = 9'sh000;
      repeat (10) @(negedge clk_sys);
      reset_n = 1'b1;
      first_short();
      recal();
      short_recal();
      repower();
      wrap_up();
   end
   initial begin
      #2_000_000;
      num_errors++;
      $display("[FAIL] %0t run timed out", $time);
      wrap_up();
   end
endmodule
